// ==== bench/pin_reset_source.sv ====
/*
  External reset source on the reset pin: holds the line low or gives a timed low pulse.
  Assumes the line has a pull-up, so a released line reads high.
*/
`timescale 1ns/1ps
`default_nettype none
module pin_reset_source (
  input  wire logic       clk_i,  // Bench clock
  input  wire logic       hold_i, // Hold the line low
  input  wire logic       go_i,   // Start a timed low pulse
  input  wire logic [3:0] len_i,  // Pulse length in cycles
  output logic            pin_o   // Line level
);
  logic [3:0] left_q = 4'h0;
  // Pulse length counter; short pulses probe the noise filter
  always_ff @(posedge clk_i) begin
    if (go_i) begin
      left_q <= len_i;
    end else if (left_q != 4'h0) begin
      left_q <= left_q - 4'h1;
    end
  end
  // Released line goes to the pull-up level, never to a stale value
  assign pin_o = ~(hold_i | (left_q != 4'h0));
endmodule : pin_reset_source
`default_nettype wire

// ==== bench/reset_source_and_cause_logic_test.sv ====
/*
  Self-checking bench for the reset source and cause logic.
  Assumes the design files and the pin source model are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin err_total++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module reset_source_and_cause_logic_test;
  localparam int PW = 20;
  logic clk = 0, rst = 1, por = 1, bor = 0, prog = 0, hold = 0, go = 0, sw_pu = 0, pen = 1, low_voltage_prog_enable = 0;
  logic pwrtn = 0, bready = 0, wclr = 0, rinst = 0, sov = 0, sun = 0, senter = 0, slp = 0, wirq = 0, sen = 1;
  logic we = 0, re = 0, kick = 1, pin, crst, wake, pdrv, poen, pu, gin, sbor;
  logic [3:0] addr = 4'h0, len = 4'h0, ev_sel;
  logic [7:0] wdata = 8'h00, rdata, v;
  logic [31:0] seed = 32'h508c;
  int err_total = 0, comparisons = 0, n;
  always #50 clk = ~clk;
  pin_reset_source u_pin (.clk_i(clk), .hold_i(hold), .go_i(go), .len_i(len), .pin_o(pin));
  reset_source_and_cause_logic #(.POWER_UP_TIMER_CYCLES(PW), .WDT_CYCLES(30), .FILT_CYCLES(4)) u_dut (
    .clk_i(clk), .rst_i(rst), .ce_i(1'b1), .por_i(por), .bor_i(bor), .prog_mode_i(prog),
    .ext_reset_pin_i(pin), .pin_pullup_sw_i(sw_pu), .ext_reset_pin_enable_i(pen),
    .low_voltage_prog_enable_i(low_voltage_prog_enable), .stack_error_reset_enable_i(sen), .power_up_timer_enable_n_i(pwrtn),
    .osc_startup_needed_i(1'b0), .osc_startup_done_i(1'b1), .brownout_circuit_ready_i(bready),
    .watchdog_clear_instr_i(wclr), .reset_instr_i(rinst), .stack_over_i(sov), .stack_under_i(sun),
    .sleep_enter_i(senter), .sleep_i(slp), .wake_irq_i(wirq), .addr_i(addr), .wdata_i(wdata),
    .we_i(we), .re_i(re), .rdata_o(rdata), .core_reset_o(crst), .wake_o(wake), .ext_reset_pin_o(pdrv),
    .ext_reset_pin_oe_n_o(poen), .pin_pullup_o(pu), .gpio_in_o(gin), .soft_brownout_enable_o(sbor));
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  // Firmware keeps the watchdog fed while kick is set
  always @(posedge clk) wclr <= kick & ~wclr;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk) begin addr <= a; wdata <= d; we <= 1'b1; end
    @(posedge clk) we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk) begin addr <= a; re <= 1'b1; end
    @(posedge clk) re <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // Count cycles until the core leaves reset, bounded so a hang is caught
  task automatic wait_run(output int c);
    c = 0;
    while (crst !== 1'b0 && c < 300) begin
      @(posedge clk);
      #1 c++;
    end
  endtask : wait_run
  task automatic cyc(input int c);
    repeat (c) @(posedge clk);
  endtask : cyc
  // Wait for a wake pulse; a watchdog wake stands one cycle, so look every cycle.
  // Stops at the first pulse so a sleeping core is not left to starve the watchdog
  task automatic wait_wake(input int lim, output logic seen);
    seen = 1'b0;
    for (int i = 0; i < lim && seen !== 1'b1; i++) begin
      @(posedge clk);
      #1 seen = wake;
    end
  endtask : wait_wake
  task automatic done(input string nm);
    `CHK("pin_drive", 2'b01, {pdrv, poen})
    $display("test %s done, errors so far %0d", nm, err_total);
  endtask : done
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  // Watchdog of the run: tests need well under 4000 cycles
  initial begin
    #2000000;
    err_total++;
    finish_test();
  end
  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    logic s;
    cyc(2);
    rst <= 1'b0;
    rd(4'h0, v);
    `CHK("cause_rst", 8'h0c, v)
    rd(4'h2, v);
    `CHK("status_rst", 8'h18, v)
    // Power-on, then programming exit, both with the power-up timer on
    for (int k = 0; k < 2; k++) begin
      wr(4'h0, 8'hff);
      @(posedge clk) begin por <= (k == 0); prog <= (k == 1); end
      cyc(3);
      @(posedge clk) begin por <= 1'b0; prog <= 1'b0; end
      wait_run(n);
      `CHK("power_up_timer_len", 1'b1, n >= PW && n <= PW + 4)
      rd(4'h0, v);
      `CHK("cause_por", 8'h0c, v & 8'hce)
    end
    done("power_up");
    // Brown-out with the pin held: timers run, release starts at once
    @(posedge clk) begin bor <= 1'b1; hold <= 1'b1; end
    cyc(3);
    @(posedge clk) bor <= 1'b0;
    cyc(40);
    #1;
    `CHK("held_by_pin", 1'b1, crst)
    @(posedge clk) hold <= 1'b0;
    wait_run(n);
    `CHK("pin_release", 1'b1, n <= 4)
    rd(4'h0, v);
    `CHK("cause_bor", 8'h00, v & 8'hc1)
    done("brownout");
    // Random register traffic, unmapped place included
    for (int k = 0; k < 6; k++) begin
      seed = lfsr(seed);
      bready <= seed[9];
      wr(4'h0, seed[7:0]);
      rd(4'h0, v);
      `CHK("cause_rw", seed[7:0] & 8'hcf, v)
      wr(4'h1, seed[15:8]);
      rd(4'h1, v);
      `CHK("borctl", {seed[15], 6'h00, seed[9]}, v)
      `CHK("soft_bor", seed[15], sbor)
      wr(4'h5, seed[23:16]);
      rd(4'h5, v);
      `CHK("unmapped", 8'h00, v)
    end
    done("registers");
    // Reset instruction, stack overflow, stack underflow
    for (int k = 0; k < 3; k++) begin
      wr(4'h0, (k == 0) ? 8'hcf : 8'h0f);
      @(posedge clk) begin rinst <= (k == 0); sov <= (k == 1); sun <= (k == 2); end
      @(posedge clk) begin rinst <= 1'b0; sov <= 1'b0; sun <= 1'b0; end
      cyc(1);
      wait_run(n);
      rd(4'h0, v);
      `CHK("cause_evt", (k == 0) ? 8'hcb : ((k == 1) ? 8'h8f : 8'h4f), v)
    end
    done("internal");
    // Short glitch is filtered, long low resets and clears the pin flag
    wr(4'h0, 8'h0f);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk) begin go <= 1'b1; len <= (k == 0) ? 4'h3 : 4'h6; end
      @(posedge clk) go <= 1'b0;
      wait_wake(0, s);
      s = 1'b0;
      repeat (8) begin
        @(posedge clk);
        #1 s = s | crst;
      end
      `CHK("pin_pulse", (k == 1), s)
      wait_run(n);
    end
    rd(4'h0, v);
    `CHK("cause_pin", 8'h07, v)
    done("pin_filter");
    // Sleep: interrupt wake, watchdog wake, pin reset
    wr(4'h0, 8'h0f);
    for (int k = 0; k < 3; k++) begin
      // Feeding stops a cycle before sleep: the core never clears and sleeps at once
      @(posedge clk) kick <= 1'b0;
      @(posedge clk) senter <= 1'b1;
      @(posedge clk) begin senter <= 1'b0; slp <= 1'b1; wirq <= (k == 0); go <= (k == 2); len <= 4'h6; end
      @(posedge clk) go <= 1'b0;
      wait_wake((k == 2) ? 12 : 40, s);
      `CHK("wake_pulse", (k != 2), s)
      @(posedge clk) begin slp <= 1'b0; wirq <= 1'b0; end
      wait_run(n);
      rd(4'h2, v);
      `CHK("status_sleep", (k == 1) ? 8'h00 : 8'h10, v)
      rd(4'h0, v);
      `CHK("cause_sleep", (k == 2) ? 8'h07 : 8'h0f, v)
      @(posedge clk) kick <= 1'b1;
    end
    done("sleep");
    // Watchdog starved while awake
    @(posedge clk) kick <= 1'b0;
    cyc(40);
    wait_run(n);
    rd(4'h2, v);
    `CHK("wdt_timeout", 1'b0, v[4])
    // Feeding resumes only after the read, since a clear sets the flag again
    @(posedge clk) kick <= 1'b1;
    done("watchdog");
    // Pin function off, then forced on by low-voltage programming
    for (int k = 0; k < 2; k++) begin
      seed = lfsr(seed);
      @(posedge clk) begin rst <= 1'b1; pen <= 1'b0; low_voltage_prog_enable <= (k == 1); pwrtn <= 1'b1; sw_pu <= seed[3]; end
      cyc(2);
      @(posedge clk) begin rst <= 1'b0; hold <= 1'b1; sen <= (k == 0); end
      cyc(12);
      #1;
      `CHK("pin_off", (k == 0) ? 1'b0 : 1'b1, crst)
      `CHK("gpio_in", (k == 0) ? 1'b0 : 1'b1, gin)
      `CHK("pullup", (k == 0) ? seed[3] : 1'b1, pu)
      @(posedge clk) hold <= 1'b0;
      wait_run(n);
    end
    // Stack reset disabled by the last sampling: overflow neither resets nor flags
    @(posedge clk) sov <= 1'b1;
    @(posedge clk) sov <= 1'b0;
    #1 s = crst;
    rd(4'h0, v);
    `CHK("stack_off", 2'b00, {s, v[7]})
    done("pin_config");
    finish_test();
  end
endmodule : reset_source_and_cause_logic_test
`default_nettype wire

// ==== rtl/reset_source_and_cause_logic.sv ====
/*
  Reset source gathering, start-up sequencing and reset cause flags.
  Assumes a free-running clk_i, power condition inputs from analog
  monitors, and a core that reports sleep, instructions and stack faults.
*/
`include "reset_source_params.svh"
`timescale 1ns/1ps
`default_nettype none

module reset_source_and_cause_logic #(
  parameter int unsigned POWER_UP_TIMER_CYCLES = `POWER_UP_TIMER_CYCLES,
  parameter int unsigned WDT_CYCLES  = `WDT_TIMEOUT_CYCLES,
  parameter int unsigned FILT_CYCLES = `PIN_FILTER_CYCLES
) (
  input  wire logic       clk_i,                   // System clock, 10 MHz
  input  wire logic       rst_i,                   // Async reset, active high
  input  wire logic       ce_i,                    // Clock enable, freezes state
  input  wire logic       por_i,                   // Power-on condition active
  input  wire logic       bor_i,                   // Brown-out condition active
  input  wire logic       prog_mode_i,             // Programming mode active
  input  wire logic       ext_reset_pin_i,         // Pin level, low resets
  input  wire logic       pin_pullup_sw_i,         // Software pull-up request
  input  wire logic       ext_reset_pin_enable_i,  // Config: pin reset enable
  input  wire logic       low_voltage_prog_enable_i, // Config: LV programming
  input  wire logic       stack_error_reset_enable_i, // Config: stack reset
  input  wire logic       power_up_timer_enable_n_i,  // Config: timer on when 0
  input  wire logic       osc_startup_needed_i,    // Clock source needs timer
  input  wire logic       osc_startup_done_i,      // Oscillator timer expired
  input  wire logic       brownout_circuit_ready_i, // Brown-out circuit ready
  input  wire logic       watchdog_clear_instr_i,  // Watchdog clear executed
  input  wire logic       reset_instr_i,           // Reset instruction executed
  input  wire logic       stack_over_i,            // Stack overflow event
  input  wire logic       stack_under_i,           // Stack underflow event
  input  wire logic       sleep_enter_i,           // Sleep instruction executed
  input  wire logic       sleep_i,                 // Core is asleep
  input  wire logic       wake_irq_i,              // Interrupt wake request
  input  wire logic [3:0] addr_i,                  // Register index
  input  wire logic [7:0] wdata_i,                 // Write data
  input  wire logic       we_i,                    // Write strobe
  input  wire logic       re_i,                    // Read strobe
  output logic      [7:0] rdata_o,                 // Read data, next cycle
  output logic            core_reset_o,            // Core held in reset
  output logic            wake_o,                  // Wake pulse, go on at PC+1
  output logic            ext_reset_pin_o,         // Pin drive value
  output logic            ext_reset_pin_oe_n_o,    // Pin drive enable, low drives
  output logic            pin_pullup_o,            // Weak pull-up on
  output logic            gpio_in_o,               // Pin as general input
  output logic            soft_brownout_enable_o   // Software brown-out enable
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  localparam int unsigned PW = $clog2(POWER_UP_TIMER_CYCLES + 1);
  localparam int unsigned WW = $clog2(WDT_CYCLES + 1);
  localparam int unsigned FW = $clog2(FILT_CYCLES + 1);

  reset_source_pkg::seq_state_e state_q, state_d;
  logic          pwr_path_q;
  logic [PW-1:0] power_up_timer_cnt_q;
  logic [WW-1:0] wdt_cnt_q;
  logic [FW-1:0] filt_cnt_q;
  logic          pin_low_q, pin_hold_prev_q;
  logic          cfg_pin_en_q, cfg_lvp_q, cfg_stack_en_q, cfg_power_up_timer_en_n_q;
  logic [7:0]    cause_q;
  logic          soft_bor_q, timeout_n_q, powerdown_n_q;
  logic          power_hold, pin_on, pin_hold, pin_ev, run;
  logic          wdt_exp, wdt_rst, wdt_wake, instr_rst, ovf_rst, unf_rst;
  logic          power_up_timer_done, ost_ok;

  // Register index decode, shared by write and read paths
  function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
    hit = (a == r);
  endfunction : hit

  // ----------------------------------------------------------------------
  // Reset sources
  // ----------------------------------------------------------------------
  // Programming mode is held like a power condition, so its exit is a POR
  assign power_hold = por_i | bor_i | prog_mode_i;
  assign pin_on     = cfg_pin_en_q | cfg_lvp_q;
  assign pin_hold   = pin_on & pin_low_q;
  assign pin_ev     = pin_hold & ~pin_hold_prev_q;
  assign run        = (state_q == reset_source_pkg::ST_RUN);
  assign wdt_exp    = (wdt_cnt_q == WW'(WDT_CYCLES - 1));
  assign wdt_rst    = run & wdt_exp & ~sleep_i;
  assign wdt_wake   = run & wdt_exp & sleep_i;
  assign instr_rst  = run & reset_instr_i;
  assign ovf_rst    = run & stack_over_i & cfg_stack_en_q;
  assign unf_rst    = run & stack_under_i & cfg_stack_en_q;
  assign power_up_timer_done  = (power_up_timer_cnt_q == PW'(POWER_UP_TIMER_CYCLES - 1));
  assign ost_ok     = ~osc_startup_needed_i | osc_startup_done_i;

  // Configuration is latched only while reset holds the core, so a
  // change while running cannot alter behaviour mid-flight
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cfg_pin_en_q    <= `RST_CFG_PIN_EN;
      cfg_lvp_q       <= `RST_CFG_LVP;
      cfg_stack_en_q  <= `RST_CFG_STACK_EN;
      cfg_power_up_timer_en_n_q <= `RST_CFG_POWER_UP_TIMER_EN_N;
    end else if (ce_i && !run) begin
      cfg_pin_en_q    <= ext_reset_pin_enable_i;
      cfg_lvp_q       <= low_voltage_prog_enable_i;
      cfg_stack_en_q  <= stack_error_reset_enable_i;
      cfg_power_up_timer_en_n_q <= power_up_timer_enable_n_i;
    end
  end

  // Noise filter: the pin must read low for FILT_CYCLES samples in a row
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      filt_cnt_q      <= '0;
      pin_low_q       <= 1'b0;
      pin_hold_prev_q <= 1'b0;
    end else if (ce_i) begin
      pin_hold_prev_q <= pin_hold;
      if (ext_reset_pin_i) begin
        filt_cnt_q <= '0;
        pin_low_q  <= 1'b0;
      end else if (filt_cnt_q == FW'(FILT_CYCLES - 1)) begin
        pin_low_q  <= 1'b1;
      end else begin
        filt_cnt_q <= filt_cnt_q + FW'(1);
      end
    end
  end

  // ----------------------------------------------------------------------
  // Start-up sequencer
  // ----------------------------------------------------------------------
  // Next state of the sequencer
  always_comb begin
    state_d = state_q;
    case (state_q)
      reset_source_pkg::ST_PWR: begin
        if (!power_hold) begin
          state_d = cfg_power_up_timer_en_n_q ? reset_source_pkg::ST_START
                                    : reset_source_pkg::ST_POWER_UP_TIMER;
        end
      end
      reset_source_pkg::ST_POWER_UP_TIMER: begin
        // Runs regardless of the pin level
        if (power_up_timer_done) begin
          state_d = reset_source_pkg::ST_START;
        end
      end
      reset_source_pkg::ST_START: begin
        if (!pin_hold && (!pwr_path_q || ost_ok)) begin
          state_d = reset_source_pkg::ST_RUN;
        end
      end
      reset_source_pkg::ST_RUN: begin
        if (pin_hold || wdt_rst || instr_rst || ovf_rst || unf_rst) begin
          state_d = reset_source_pkg::ST_START;
        end
      end
      default: state_d = reset_source_pkg::ST_PWR;
    endcase
    if (power_hold) begin
      state_d = reset_source_pkg::ST_PWR;
    end
  end

  // State, power path marker and core reset output
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q      <= reset_source_pkg::ST_PWR;
      pwr_path_q   <= 1'b1;
      core_reset_o <= 1'b1;
    end else if (ce_i) begin
      state_q      <= state_d;
      core_reset_o <= (state_d != reset_source_pkg::ST_RUN);
      if (power_hold) begin
        pwr_path_q <= 1'b1;
      end else if (state_d == reset_source_pkg::ST_RUN) begin
        pwr_path_q <= 1'b0;
      end
    end
  end

  // Power-up timer counts only in its own state
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      power_up_timer_cnt_q <= '0;
    end else if (ce_i) begin
      if (state_q == reset_source_pkg::ST_POWER_UP_TIMER && !power_up_timer_done) begin
        power_up_timer_cnt_q <= power_up_timer_cnt_q + PW'(1);
      end else if (state_q != reset_source_pkg::ST_POWER_UP_TIMER) begin
        power_up_timer_cnt_q <= '0;
      end
    end
  end

  // Watchdog: restarts on clear instruction, on expiry and outside run
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wdt_cnt_q <= '0;
    end else if (ce_i) begin
      if (!run || watchdog_clear_instr_i || wdt_exp) begin
        wdt_cnt_q <= '0;
      end else begin
        wdt_cnt_q <= wdt_cnt_q + WW'(1);
      end
    end
  end

  // Wake pulse: execution continues at the next instruction
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wake_o <= 1'b0;
    end else if (ce_i) begin
      wake_o <= wdt_wake | (run & sleep_i & wake_irq_i);
    end
  end

  // ----------------------------------------------------------------------
  // Pin handling
  // ----------------------------------------------------------------------
  // Never drives the pin; pull-up forced on while the reset function owns it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ext_reset_pin_o      <= 1'b0;
      ext_reset_pin_oe_n_o <= 1'b1;
      pin_pullup_o         <= 1'b1;
      gpio_in_o            <= 1'b1;
    end else if (ce_i) begin
      ext_reset_pin_o      <= 1'b0;
      ext_reset_pin_oe_n_o <= 1'b1;
      pin_pullup_o         <= pin_on | pin_pullup_sw_i;
      gpio_in_o            <= pin_on | ext_reset_pin_i;
    end
  end

  // ----------------------------------------------------------------------
  // Cause flags; hardware events win over a firmware write in one cycle
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cause_q <= 8'h0c;
    end else if (ce_i) begin
      if (power_hold) begin
        cause_q[`BIT_STACK_OVER]    <= 1'b0;
        cause_q[`BIT_STACK_UNDER]   <= 1'b0;
        cause_q[`BIT_PIN_RESET_N]   <= 1'b1;
        cause_q[`BIT_INSTR_RESET_N] <= 1'b1;
        cause_q[`BIT_BROWNOUT_N]    <= 1'b0;
        if (por_i || prog_mode_i) begin
          cause_q[`BIT_POWER_ON_N]  <= 1'b0;
        end
      end else begin
        if (we_i && hit(addr_i, `REG_CAUSE_FLAGS)) begin
          cause_q <= wdata_i & 8'hcf;
        end
        if (pin_ev) begin
          cause_q[`BIT_PIN_RESET_N] <= 1'b0;
        end
        if (instr_rst) begin
          cause_q[`BIT_INSTR_RESET_N] <= 1'b0;
        end
        if (ovf_rst) begin
          cause_q[`BIT_STACK_OVER] <= 1'b1;
        end
        if (unf_rst) begin
          cause_q[`BIT_STACK_UNDER] <= 1'b1;
        end
      end
    end
  end

  // Timeout and power-down flags, read-only to firmware
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      timeout_n_q   <= 1'b1;
      powerdown_n_q <= 1'b1;
    end else if (ce_i) begin
      if (power_hold || watchdog_clear_instr_i) begin
        timeout_n_q   <= 1'b1;
        powerdown_n_q <= 1'b1;
      end else if (wdt_wake) begin
        timeout_n_q   <= 1'b0;
        powerdown_n_q <= 1'b0;
      end else if (wdt_rst) begin
        timeout_n_q   <= 1'b0;
      end else if (pin_ev && sleep_i) begin
        timeout_n_q   <= 1'b1;
        powerdown_n_q <= 1'b0;
      end else if (sleep_enter_i && run) begin
        timeout_n_q   <= 1'b1;
        powerdown_n_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Brown-out control and read port
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      soft_bor_q <= `RST_SOFT_BOR_EN;
    end else if (ce_i && we_i && hit(addr_i, `REG_BROWNOUT_CTRL)) begin
      soft_bor_q <= wdata_i[`BIT_SOFT_BOR_EN];
    end
  end

  assign soft_brownout_enable_o = soft_bor_q;

  // Read data stands for the cycle after the strobe only; unmapped reads 0
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (ce_i) begin
      rdata_o <= 8'h00;
      if (re_i && hit(addr_i, `REG_CAUSE_FLAGS)) begin
        rdata_o <= cause_q;
      end else if (re_i && hit(addr_i, `REG_BROWNOUT_CTRL)) begin
        rdata_o <= {soft_bor_q, 6'h00, brownout_circuit_ready_i};
      end else if (re_i && hit(addr_i, `REG_CORE_STATUS)) begin
        rdata_o <= {3'h0, timeout_n_q, powerdown_n_q, 3'h0};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_pin_off;
    !cfg_pin_en_q && !cfg_lvp_q |-> !pin_hold;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin reset active while disabled");

  property p_pin_hold;
    ce_i && pin_hold |=> core_reset_o;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin low did not hold reset");

  property p_filter;
    ce_i && !pin_low_q && ext_reset_pin_i |=> !pin_low_q;
  endproperty
  a_filter: assert property (p_filter) else $error("pin glitch passed filter");

  property p_no_drive;
    ext_reset_pin_oe_n_o && !ext_reset_pin_o;
  endproperty
  a_no_drive: assert property (p_no_drive) else $error("reset pin driven");

  property p_pullup_sw;
    ce_i && !pin_on |=> pin_pullup_o == $past(pin_pullup_sw_i);
  endproperty
  a_pullup_sw: assert property (p_pullup_sw) else $error("pull-up not under software");

  property p_wdt_reset;
    ce_i && wdt_rst && !power_hold && !watchdog_clear_instr_i |=> !timeout_n_q && core_reset_o;
  endproperty
  a_wdt_reset: assert property (p_wdt_reset) else $error("watchdog reset missing");

  property p_instr;
    ce_i && instr_rst && !power_hold |=> !cause_q[`BIT_INSTR_RESET_N] && core_reset_o;
  endproperty
  a_instr: assert property (p_instr) else $error("reset instruction not recorded");

  property p_pin_flag;
    ce_i && pin_ev && !power_hold |=> !cause_q[`BIT_PIN_RESET_N];
  endproperty
  a_pin_flag: assert property (p_pin_flag) else $error("pin flag not cleared");

  property p_wdt_wake;
    ce_i && wdt_wake && !power_hold && !watchdog_clear_instr_i |=> wake_o && !timeout_n_q && !powerdown_n_q;
  endproperty
  a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake wrong");

  c_run: cover property (state_q == reset_source_pkg::ST_PWR ##[1:200] run);
  c_pin_reset: cover property (run && pin_hold ##1 !run);
  c_wake: cover property (wake_o);

endmodule : reset_source_and_cause_logic

`default_nettype wire

// ==== rtl/reset_source_params.svh ====
/*
  Constants of the reset source and cause logic: register offsets, field
  positions, reset values and timing figures.
  Assumes it is included by bare name after the package.
*/
`ifndef RESET_SOURCE_PARAMS_SVH
`define RESET_SOURCE_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (word index on the plain register port)
// ----------------------------------------------------------------------
`define REG_CAUSE_FLAGS     4'h0
`define REG_BROWNOUT_CTRL   4'h1
`define REG_CORE_STATUS     4'h2

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define BIT_STACK_OVER      7
`define BIT_STACK_UNDER     6
`define BIT_PIN_RESET_N     3
`define BIT_INSTR_RESET_N   2
`define BIT_POWER_ON_N      1
`define BIT_BROWNOUT_N      0
`define BIT_SOFT_BOR_EN     7
`define BIT_BOR_READY       0
`define BIT_TIMEOUT_N       4
`define BIT_POWERDOWN_N     3

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define RST_SOFT_BOR_EN     1'b1
`define RST_CFG_PIN_EN      1'b1
`define RST_CFG_LVP         1'b0
`define RST_CFG_STACK_EN    1'b1
`define RST_CFG_POWER_UP_TIMER_EN_N   1'b1

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_FREQ_KHZ        10000
`define POWER_UP_TIMER_TIME_MS        64
`define POWER_UP_TIMER_CYCLES         (`POWER_UP_TIMER_TIME_MS * `CLK_FREQ_KHZ)
`define WDT_TIMEOUT_CYCLES  16384
`define PIN_FILTER_CYCLES   4

`endif

// ==== rtl/reset_source_pkg.sv ====
/*
  Types of the reset source and cause logic.
  Assumes nothing of its surroundings.
*/
package reset_source_pkg;

  // Start-up sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_PWR   = 4'b0001,
    ST_POWER_UP_TIMER  = 4'b0010,
    ST_START = 4'b0100,
    ST_RUN   = 4'b1000
  } seq_state_e;

endpackage : reset_source_pkg
